// >>> spi_eeprom_pkg.sv
// Shared constants and types for the serial EEPROM command and protection logic
package spi_eeprom_pkg;

	// ---------------------------------------------------------------
	// Opcodes (bit 3 is masked off before compare)
	// ---------------------------------------------------------------
	localparam logic [7:0] OPC_MASK = 8'hf7;
	localparam logic [7:0] OPC_LATCH_SET = 8'h06;
	localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;
	localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
	localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;

	// ---------------------------------------------------------------
	// Status register layout and reset values
	// ---------------------------------------------------------------
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_BP_LO_BIT = 2;
	localparam int ST_BP_HI_BIT = 3;
	localparam int ST_PPE_BIT = 7;
	localparam logic [7:0] ST_BUSY_VALUE = 8'hff;
	localparam logic [1:0] BP_RESET = 2'b00;
	localparam logic PPE_RESET = 1'b0;
	localparam logic [1:0] BP_NONE = 2'b00;
	localparam logic [1:0] BP_QUARTER = 2'b01;
	localparam logic [1:0] BP_HALF = 2'b10;

	// ---------------------------------------------------------------
	// Framing and array geometry
	// ---------------------------------------------------------------
	localparam int ADDR_FIELD_BITS = 16;
	localparam int PAGE_BITS = 5;
	localparam int PAGE_BYTES = 32;
	localparam int ADDR_BITS_DEFAULT = 13;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int REF_CLK_MHZ = 100;
	localparam int WRITE_CYCLE_NS = 5_000_000;
	// Longest time: rounds down
	localparam int WRITE_CYCLE_CYCLES = (WRITE_CYCLE_NS * REF_CLK_MHZ) / 1000;

	typedef enum {
		cmd_none, cmd_latch_set, cmd_latch_clear, cmd_status_read,
		cmd_status_write, cmd_array_read, cmd_array_write
	} cmd_kind_t;

	typedef enum {ph_opcode, ph_addr, ph_data, ph_dead} link_phase_t;

	typedef enum {sys_idle, sys_program, sys_wait} sys_state_t;

endpackage

// >>> spi_eeprom_core.sv
// Serial EEPROM command interpreter, status/protect register and array
`timescale 1ns/10ps

module spi_eeprom_core
	import spi_eeprom_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_BITS_DEFAULT,
	parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
	input wire logic ref_clk_i, // System clock, 100 MHz
	input wire logic arst_n_i, // Asynchronous reset, active low
	input wire logic spi_sck_i, // Serial clock from host
	input wire logic spi_cs_n_i, // Chip select, active low
	input wire logic spi_si_i, // Serial data in
	input wire logic spi_hold_n_i, // Hold, active low
	input wire logic wp_n_i, // Write protect pin, active low
	output logic spi_so_o, // Serial data out
	output logic spi_so_oe_o // Serial out enable, high drives
);

	localparam int MEM_BYTES = 1 << ADDR_BITS;
	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

	// ---------------------------------------------------------------
	// Reset release and system side synchronisers
	// ---------------------------------------------------------------
	logic rst_meta;
	logic sys_rst_n;
	logic cs_meta;
	logic cs_sync;
	logic wp_meta;
	logic wp_sync;
	logic tgl_meta;
	logic tgl_sync;
	logic tgl_seen;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta <= 1'b0;
			sys_rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			sys_rst_n <= rst_meta;
		end
	end

	// ---------------------------------------------------------------
	// Link side state
	// ---------------------------------------------------------------
	logic link_rst_n;
	link_phase_t phase;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic addr_byte;
	logic [7:0] rx_byte;
	cmd_kind_t rx_kind;
	cmd_kind_t req_kind;
	logic req_tgl;
	logic [ADDR_FIELD_BITS-1:0] addr;
	logic [ADDR_FIELD_BITS-1:0] next_addr;
	logic [ADDR_BITS-1:0] rd_next;
	logic [7:0] page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] buf_mask;
	logic [1:0] byte_cnt;
	logic ends_on_byte;
	logic [7:0] sr_data;
	logic [7:0] tx_byte;
	logic [7:0] st_meta;
	logic [7:0] st_sync;
	logic sending;
	logic [7:0] status_view;
	logic [7:0] mem [MEM_BYTES];

	// Sequencer and output state restart on every deselect; frame results do not
	assign link_rst_n = ~spi_cs_n_i & sys_rst_n;
	assign rx_byte = {shift[6:0], spi_si_i};
	assign next_addr = {addr[ADDR_FIELD_BITS-2:0], spi_si_i};
	assign rd_next = ADDR_BITS'(addr[ADDR_BITS-1:0] + 1'b1);
	assign sending = (phase == ph_data) &&
		(req_kind == cmd_status_read || req_kind == cmd_array_read);

	function automatic cmd_kind_t decode(input logic [7:0] op);
		logic [7:0] m;
		m = op & OPC_MASK;
		unique case (m)
			OPC_LATCH_SET: decode = cmd_latch_set;
			OPC_LATCH_CLEAR: decode = cmd_latch_clear;
			OPC_STATUS_READ: decode = cmd_status_read;
			OPC_STATUS_WRITE: decode = cmd_status_write;
			OPC_ARRAY_READ: decode = cmd_array_read;
			OPC_ARRAY_WRITE: decode = cmd_array_write;
			default: decode = cmd_none;
		endcase
	endfunction

	// Busy filter: a frame started during a write cycle keeps only status read
	always_comb begin
		rx_kind = decode(rx_byte);
		if (st_sync[ST_BUSY_BIT] && rx_kind != cmd_status_read) begin
			rx_kind = cmd_none;
		end
	end

	// Status copy into the link domain; stable long before any opcode ends
	always_ff @(posedge spi_sck_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			st_meta <= '0;
			st_sync <= '0;
		end else begin
			st_meta <= status_view;
			st_sync <= st_meta;
		end
	end

	// ---------------------------------------------------------------
	// Frame sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge spi_sck_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			phase <= ph_opcode;
			bit_cnt <= '0;
			shift <= '0;
			addr_byte <= 1'b0;
		end else if (spi_hold_n_i) begin
			shift <= rx_byte;
			bit_cnt <= bit_cnt + 3'd1;
			unique case (phase)
				ph_opcode: begin
					if (bit_cnt == 3'd7) begin
						if (rx_kind == cmd_none) begin
							phase <= ph_dead;
						end else if (rx_kind == cmd_array_read ||
							rx_kind == cmd_array_write) begin
							phase <= ph_addr;
						end else begin
							phase <= ph_data;
						end
					end
				end
				ph_addr: begin
					if (bit_cnt == 3'd7) begin
						addr_byte <= ~addr_byte;
						if (addr_byte) begin
							phase <= ph_data;
						end
					end
				end
				ph_data: begin
				end
				ph_dead: begin
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Frame results: survive deselect for the system side to collect
	// ---------------------------------------------------------------
	always_ff @(posedge spi_sck_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			req_kind <= cmd_none;
			req_tgl <= 1'b0;
			addr <= '0;
			buf_mask <= '0;
			byte_cnt <= '0;
			ends_on_byte <= 1'b0;
			sr_data <= '0;
		end else if (spi_hold_n_i && !spi_cs_n_i) begin
			ends_on_byte <= 1'b0;
			if (phase == ph_opcode && bit_cnt == 3'd7) begin
				req_kind <= rx_kind;
				req_tgl <= ~req_tgl;
				buf_mask <= '0;
				byte_cnt <= '0;
			end
			if (phase == ph_addr) begin
				addr <= next_addr;
			end
			if (phase == ph_data && bit_cnt == 3'd7) begin
				ends_on_byte <= 1'b1;
				if (byte_cnt != 2'd3) begin
					byte_cnt <= byte_cnt + 2'd1;
				end
				if (byte_cnt == 2'd0) begin
					sr_data <= rx_byte;
				end
				if (req_kind == cmd_array_write) begin
					buf_mask[addr[PAGE_BITS-1:0]] <= 1'b1;
					// Upper page bits held, low bits wrap in the page
					addr[PAGE_BITS-1:0] <= addr[PAGE_BITS-1:0] + 1'b1;
				end else if (req_kind == cmd_array_read) begin
					addr[ADDR_BITS-1:0] <= rd_next;
				end
			end
		end
	end

	always_ff @(posedge spi_sck_i) begin
		if (spi_hold_n_i && !spi_cs_n_i && phase == ph_data && bit_cnt == 3'd7 &&
			req_kind == cmd_array_write) begin
			page_buf[addr[PAGE_BITS-1:0]] <= rx_byte;
		end
	end

	// Next byte to send; array read is safe since writes happen only when busy
	always_ff @(posedge spi_sck_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_byte <= '0;
		end else if (spi_hold_n_i && bit_cnt == 3'd7) begin
			if (phase == ph_opcode && rx_kind == cmd_status_read) begin
				tx_byte <= st_sync;
			end else if (phase == ph_addr && addr_byte && req_kind == cmd_array_read) begin
				tx_byte <= mem[next_addr[ADDR_BITS-1:0]];
			end else if (phase == ph_data && req_kind == cmd_status_read) begin
				tx_byte <= st_sync;
			end else if (phase == ph_data && req_kind == cmd_array_read) begin
				tx_byte <= mem[rd_next];
			end
		end
	end

	// ---------------------------------------------------------------
	// Serial output on falling edges
	// ---------------------------------------------------------------
	always_ff @(negedge spi_sck_i or negedge link_rst_n) begin
		if (!link_rst_n) begin
			spi_so_o <= 1'b0;
			spi_so_oe_o <= 1'b0;
		end else begin
			spi_so_oe_o <= sending && spi_hold_n_i;
			if (spi_hold_n_i) begin
				spi_so_o <= tx_byte[~bit_cnt];
			end
		end
	end

	// ---------------------------------------------------------------
	// System side: frame completion detect
	// ---------------------------------------------------------------
	logic frame_done;
	logic hw_protect;
	logic write_ok;
	sys_state_t state;
	logic latch;
	logic [1:0] bp;
	logic ppe;
	logic [CNT_W-1:0] busy_cnt;
	logic [PAGE_BITS-1:0] prog_idx;
	logic [ADDR_BITS-1:0] prog_addr;

	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			wp_meta <= 1'b1;
			wp_sync <= 1'b1;
			tgl_meta <= 1'b0;
			tgl_sync <= 1'b0;
			tgl_seen <= 1'b0;
		end else begin
			cs_meta <= spi_cs_n_i;
			cs_sync <= cs_meta;
			wp_meta <= wp_n_i;
			wp_sync <= wp_meta;
			tgl_meta <= req_tgl;
			tgl_sync <= tgl_meta;
			if (cs_sync) begin
				tgl_seen <= tgl_sync;
			end
		end
	end

	// A new opcode was completed and the frame has closed
	assign frame_done = cs_sync && (tgl_sync != tgl_seen);
	assign hw_protect = !wp_sync && ppe;
	// Whole bytes only; a frame cut mid-byte is dropped
	assign write_ok = latch && ends_on_byte && (byte_cnt != 2'd0);
	assign prog_addr = {addr[ADDR_BITS-1:PAGE_BITS], prog_idx};

	function automatic logic is_protected(input logic [ADDR_BITS-1:0] a,
		input logic [1:0] code);
		unique case (code)
			BP_NONE: is_protected = 1'b0;
			BP_QUARTER: is_protected = &a[ADDR_BITS-1:ADDR_BITS-2];
			BP_HALF: is_protected = a[ADDR_BITS-1];
			default: is_protected = 1'b1;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Command execution and write cycle
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			state <= sys_idle;
			latch <= 1'b0;
			bp <= BP_RESET;
			ppe <= PPE_RESET;
			busy_cnt <= '0;
			prog_idx <= '0;
		end else begin
			unique case (state)
				sys_idle: begin
					busy_cnt <= '0;
					prog_idx <= '0;
					if (frame_done) begin
						unique case (req_kind)
							cmd_latch_set: latch <= 1'b1;
							cmd_latch_clear: latch <= 1'b0;
							cmd_status_write: begin
								// Refusal also keeps the enable bit set while pin low
								if (write_ok && !hw_protect) begin
									bp <= {sr_data[ST_BP_HI_BIT], sr_data[ST_BP_LO_BIT]};
									ppe <= sr_data[ST_PPE_BIT];
									state <= sys_wait;
								end
							end
							cmd_array_write: begin
								if (write_ok) begin
									state <= sys_program;
								end
							end
							default: begin
							end
						endcase
					end
				end
				sys_program: begin
					busy_cnt <= busy_cnt + 1'b1;
					prog_idx <= prog_idx + 1'b1;
					if (&prog_idx) begin
						state <= sys_wait;
					end
				end
				sys_wait: begin
					busy_cnt <= busy_cnt + 1'b1;
					if (busy_cnt >= CNT_W'(WRITE_CYCLES - 1)) begin
						state <= sys_idle;
						latch <= 1'b0;
					end
				end
			endcase
		end
	end

	// Array cells keep their contents across reset
	always_ff @(posedge ref_clk_i) begin
		if (state == sys_program && buf_mask[prog_idx] && !is_protected(prog_addr, bp)) begin
			mem[prog_addr] <= page_buf[prog_idx];
		end
	end

	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			status_view <= '0;
		end else if (state != sys_idle) begin
			status_view <= ST_BUSY_VALUE;
		end else begin
			status_view <= '0;
			status_view[ST_LATCH_BIT] <= latch;
			status_view[ST_BP_LO_BIT] <= bp[0];
			status_view[ST_BP_HI_BIT] <= bp[1];
			status_view[ST_PPE_BIT] <= ppe;
		end
	end

endmodule

// >>> spi_eeprom_asserts.sv
// Concurrent checks on the serial EEPROM core pins
`timescale 1ns/10ps
module spi_eeprom_asserts
	import spi_eeprom_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_BITS_DEFAULT,
	parameter int WRITE_CYCLES = WRITE_CYCLE_CYCLES
) (
	input wire logic ref_clk_i, // System clock
	input wire logic arst_n_i, // Reset, active low
	input wire logic spi_sck_i, // Serial clock
	input wire logic spi_cs_n_i, // Chip select, active low
	input wire logic spi_si_i, // Serial in
	input wire logic spi_hold_n_i, // Hold, active low
	input wire logic wp_n_i, // Protect pin, active low
	input wire logic spi_so_o, // Serial out
	input wire logic spi_so_oe_o // Serial out enable
);
	// ----------------------------------------------------------
	// Frame tracking on the link clock
	// ----------------------------------------------------------
	logic [5:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] op_q;
	logic [7:0] op_m;
	logic op_silent;
	logic op_known;
	// Saturates so long reads never alias back into the opcode phase
	always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			bit_cnt <= 6'h00;
		end else if (bit_cnt != 6'h3f) begin
			bit_cnt <= bit_cnt + 6'h01;
		end
	end
	always_ff @(posedge spi_sck_i) begin
		shift <= {shift[6:0], spi_si_i};
	end
	always_ff @(posedge spi_sck_i) begin
		if (bit_cnt == 6'h07) begin
			op_q <= {shift[6:0], spi_si_i};
		end
	end
	assign op_m = op_q & OPC_MASK;
	assign op_silent = (op_m == OPC_LATCH_SET) || (op_m == OPC_LATCH_CLEAR)
		|| (op_m == OPC_STATUS_WRITE) || (op_m == OPC_ARRAY_WRITE);
	assign op_known = op_silent || (op_m == OPC_STATUS_READ) || (op_m == OPC_ARRAY_READ);
	sequence status_op_s;
		(bit_cnt == 6'h08) && ((shift & OPC_MASK) == OPC_STATUS_READ);
	endsequence
	sequence addr_phase_s;
		(op_m == OPC_ARRAY_READ) && (bit_cnt >= 6'h08) && (bit_cnt < 6'h18);
	endsequence
	// ----------------------------------------------------------
	// Properties
	// ----------------------------------------------------------
	early_oe_a:
		assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i) (bit_cnt < 6'h08) |-> !spi_so_oe_o)
		else $error("Output enabled during opcode");
	status_oe_a:
		assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i) status_op_s |-> spi_so_oe_o)
		else $error("Status read not driven");
	addr_quiet_a:
		assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i) addr_phase_s |-> !spi_so_oe_o)
		else $error("Output enabled during address");
	write_quiet_a:
		assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i)
			(bit_cnt >= 6'h08) && op_silent |-> !spi_so_oe_o) else $error("Write command drove output");
	bad_op_quiet_a:
		assert property (@(posedge spi_sck_i) disable iff (spi_cs_n_i)
			(bit_cnt >= 6'h08) && !op_known |-> !spi_so_oe_o) else $error("Unknown opcode drove output");
	cs_idle_a:
		assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) spi_cs_n_i |-> !spi_so_oe_o)
		else $error("Output enabled while deselected");
	reset_quiet_a:
		assert property (@(posedge ref_clk_i) !arst_n_i |-> !spi_so_oe_o && !spi_so_o)
		else $error("Outputs active in reset");
	so_steady_a:
		assert property (@(posedge ref_clk_i) disable iff (!arst_n_i || spi_cs_n_i)
			spi_sck_i && $past(spi_sck_i) && !$past(spi_cs_n_i) |-> $stable(spi_so_o))
		else $error("Serial out moved while clock high");
	oe_rise_a:
		assert property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(spi_so_oe_o) |-> !spi_sck_i)
		else $error("Output enable rose outside clock low");
endmodule
bind spi_eeprom_core spi_eeprom_asserts #(.ADDR_BITS(ADDR_BITS), .WRITE_CYCLES(WRITE_CYCLES))
	i_spi_eeprom_asserts (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .spi_sck_i(spi_sck_i),
	.spi_cs_n_i(spi_cs_n_i), .spi_si_i(spi_si_i), .spi_hold_n_i(spi_hold_n_i), .wp_n_i(wp_n_i),
	.spi_so_o(spi_so_o), .spi_so_oe_o(spi_so_oe_o));

// >>> spi_host_model.sv
// Behavioural mode-0 SPI host that runs frames against the EEPROM core
`timescale 1ns/10ps
module spi_host_model (
	output logic spi_sck_o, // Serial clock, low between frames
	output logic spi_cs_n_o, // Chip select, active low
	output logic spi_si_o, // Serial data to device
	output logic spi_hold_n_o, // Hold, kept inactive
	input wire logic spi_so_i, // Serial data from device
	input wire logic spi_so_oe_i // Device drives serial out
);
	logic [7:0] tx_buf [0:7];
	logic [7:0] rx_buf [0:7];
	logic oe_buf [0:7];
	// Short select pulse at start gives the frame logic a clean reset edge
	initial begin
		spi_sck_o = 1'b0;
		spi_cs_n_o = 1'b0;
		spi_si_o = 1'b0;
		spi_hold_n_o = 1'b1;
		#2 spi_cs_n_o = 1'b1;
	end
	task automatic run(input int n);
		spi_cs_n_o = 1'b0;
		for (int b = 0; b < n; b++) begin
			oe_buf[b] = 1'b0;
			for (int i = 7; i >= 0; i--) begin
				spi_si_o = tx_buf[b][i];
				#80 spi_sck_o = 1'b1;
				// Undriven line reads as the inverse, never a lucky match
				rx_buf[b][i] = spi_so_oe_i ? spi_so_i : ~spi_so_i;
				oe_buf[b] = oe_buf[b] | spi_so_oe_i;
				#80 spi_sck_o = 1'b0;
			end
		end
		#40 spi_cs_n_o = 1'b1;
		spi_si_o = ~spi_si_o;
		#200;
	endtask
endmodule

// >>> tb_top.sv
// Self-checking bench for the serial EEPROM command and protection core
`timescale 1ns/10ps
module tb_top;
	import spi_eeprom_pkg::*;
	logic ref_clk = 1'b0;
	// Starts high so reset sees a real falling edge before the first clock
	logic arst_n = 1'b1;
	logic wp_n = 1'b1;
	wire sck;
	wire cs_n;
	wire si;
	wire hold_n;
	wire so;
	wire so_oe;
	int bad_count = 0;
	int checks = 0;
	logic [7:0] st;
	always #5 ref_clk = ~ref_clk;
	spi_eeprom_core #(.WRITE_CYCLES(2000)) i_spi_eeprom_core (.ref_clk_i(ref_clk),
		.arst_n_i(arst_n), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_si_i(si),
		.spi_hold_n_i(hold_n), .wp_n_i(wp_n), .spi_so_o(so), .spi_so_oe_o(so_oe));
	spi_host_model i_spi_host_model (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_si_o(si),
		.spi_hold_n_o(hold_n), .spi_so_i(so), .spi_so_oe_i(so_oe));
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic frame(input int n, input logic [39:0] bytes);
		for (int k = 0; k < n; k++) i_spi_host_model.tx_buf[k] = bytes[39 - 8 * k -: 8];
		@(negedge ref_clk);
		#3;
		i_spi_host_model.run(n);
	endtask
	function automatic logic [7:0] rx(input int k);
		return i_spi_host_model.rx_buf[k];
	endfunction
	task automatic status();
		frame(2, {OPC_STATUS_READ | 8'h08, 32'h0000_0000});
		st = rx(1);
	endtask
	task automatic wait_ready();
		status();
		for (int k = 0; k < 12 && st[0] !== 1'b0; k++) status();
		check("ready", {7'h00, st[0]}, 8'h00);
	endtask
	task automatic latch_set();
		frame(1, {OPC_LATCH_SET, 32'h0000_0000});
	endtask
	task automatic write2(input logic [15:0] a, input logic [15:0] d);
		latch_set();
		frame(5, {OPC_ARRAY_WRITE, a, d});
		wait_ready();
	endtask
	task automatic read2(input logic [15:0] a);
		frame(5, {OPC_ARRAY_READ | 8'h08, a, 16'h0000});
	endtask
	task automatic wr_status(input logic [7:0] v);
		latch_set();
		frame(2, {OPC_STATUS_WRITE, v, 24'h00_0000});
		wait_ready();
	endtask
	task automatic t_power();
		status();
		check("status reset", st, 8'h00);
		frame(1, {OPC_LATCH_SET | 8'h08, 32'h0000_0000});
		status();
		check("latch set", st, 8'h02);
		frame(1, {OPC_LATCH_CLEAR | 8'h08, 32'h0000_0000});
		status();
		check("latch clear", st, 8'h00);
	endtask
	task automatic t_page();
		latch_set();
		frame(5, {OPC_ARRAY_WRITE, 16'h001f, 16'ha55a});
		status();
		check("busy status", st, ST_BUSY_VALUE);
		read2(16'h001f);
		check("busy read", {7'h00, i_spi_host_model.oe_buf[3]}, 8'h00);
		wait_ready();
		check("latch auto clear", st, 8'h00);
		write2(16'hffff, 16'h3cc3);
		read2(16'h1fff);
		check("top byte", rx(3), 8'h3c);
		check("rollover", rx(4), 8'h5a);
		read2(16'h1fe0);
		check("page wrap", rx(3), 8'hc3);
	endtask
	task automatic t_nolatch();
		frame(5, {OPC_ARRAY_WRITE, 16'h001f, 16'h0000});
		status();
		check("no latch idle", st, 8'h00);
		read2(16'h001f);
		check("no latch data", rx(3), 8'ha5);
	endtask
	task automatic t_protect();
		wr_status(8'h04);
		check("block protect", st, 8'h04);
		write2(16'h1fff, 16'h9999);
		read2(16'h1fff);
		check("protected byte", rx(3), 8'h3c);
		write2(16'h001f, 16'h6677);
		read2(16'h001f);
		check("open byte", rx(3), 8'h66);
	endtask
	task automatic t_wp();
		wr_status(8'h84);
		check("enable bit", st, 8'h84);
		@(negedge ref_clk) wp_n = 1'b0;
		wr_status(8'h00);
		check("pin refuses", st & 8'hfd, 8'h84);
		frame(1, {OPC_LATCH_CLEAR, 32'h0000_0000});
		status();
		check("clear under pin", st, 8'h84);
		@(negedge ref_clk) wp_n = 1'b1;
		wr_status(8'h00);
		check("pin released", st, 8'h00);
	endtask
	task automatic t_badop();
		frame(3, {8'hff, 32'h0000_0000});
		check("bad opcode", {7'h00, i_spi_host_model.oe_buf[2]}, 8'h00);
	endtask
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		#1 arst_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		t_power();
		t_page();
		t_nolatch();
		t_protect();
		t_wp();
		t_badop();
		print_verdict();
	end
	// Run needs roughly 300 us; limit well above that
	initial begin
		#800_000;
		bad_count++;
		print_verdict();
	end
endmodule
